// ===== dsram_defines.svh
`ifndef DSRAM_DEFINES_SVH
`define DSRAM_DEFINES_SVH

`define DSRAM_ADDR_W 13
`define DSRAM_DATA_W 9
`define DSRAM_WORDS 8192
`define DSRAM_CLK_PS 4000
// times in ps, fastest speed grade figures
`define DSRAM_WP_PS 15000
`define DSRAM_WHZ_PS 8000
`define DSRAM_DW_PS 10000
// read access: select-high path is the slowest at the same edge
`define DSRAM_ACC_PS 25000
`define DSRAM_WR2_PS 5000
`define DSRAM_OHZ_PS 8000
// least times round up, whole cycles
`define DSRAM_CEIL(t) (((t) + `DSRAM_CLK_PS - 1) / `DSRAM_CLK_PS)
`define DSRAM_WP_CYC `DSRAM_CEIL(`DSRAM_WP_PS)
`define DSRAM_FLOAT_CYC `DSRAM_CEIL(`DSRAM_WHZ_PS)
`define DSRAM_DW_CYC `DSRAM_CEIL(`DSRAM_DW_PS)
// first edge strictly after valid data, then two flops; no edge-time race
`define DSRAM_RD_CYC (`DSRAM_CEIL(`DSRAM_ACC_PS + 1) + 2)
`define DSRAM_REC_CYC `DSRAM_CEIL(`DSRAM_WR2_PS)
`define DSRAM_OHZ_CYC `DSRAM_CEIL(`DSRAM_OHZ_PS)

`endif

// ===== dsram_pkg.sv
package dsram_pkg;
  typedef enum logic [2:0] {
    DSRAM_IDLE  = 3'b000,
    DSRAM_WSTRB = 3'b001,
    DSRAM_WDATA = 3'b010,
    DSRAM_READ  = 3'b011,
    DSRAM_REC   = 3'b100
  } dsram_state_e;
  typedef logic [7:0] dsram_cnt_t;
endpackage

// ===== dsram_ctrl.sv
`timescale 1ns/1ps
`include "dsram_defines.svh"

// Function
// - address lines never change while write strobe is low; a write moves them at the edge where strobe falls
// - with output enable low, strobe covers float time plus data setup
// - no write data driven while device may still drive the bus
// - read needs strobe high, both selects active, output enable low
module dsram_ctrl #(
  parameter int ADDR_W = `DSRAM_ADDR_W,
  parameter int DATA_W = `DSRAM_DATA_W
) (
  input  wire logic              clock,
  input  wire logic              rst_b,
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_rdata,
  output logic [ADDR_W-1:0]      mem_addr,
  output logic                   select_active_low_b,
  output logic                   select_active_high,
  output logic                   output_enable_b,
  output logic                   write_strobe_b,
  output logic [DATA_W-1:0]      mem_dq_out,
  output logic                   mem_dq_oe,
  input  wire logic [DATA_W-1:0] mem_dq_in
);

  localparam dsram_pkg::dsram_cnt_t WP_CYC  = 8'(`DSRAM_WP_CYC);
  localparam dsram_pkg::dsram_cnt_t FLT_CYC = 8'(`DSRAM_FLOAT_CYC);
  localparam dsram_pkg::dsram_cnt_t DW_CYC  = 8'(`DSRAM_DW_CYC);
  localparam dsram_pkg::dsram_cnt_t RD_CYC  = 8'(`DSRAM_RD_CYC);
  localparam dsram_pkg::dsram_cnt_t REC_CYC = 8'(`DSRAM_REC_CYC);
  localparam dsram_pkg::dsram_cnt_t OHZ_CYC = 8'(`DSRAM_OHZ_CYC);

  // data pins come from another device: two flops before use
  logic [DATA_W-1:0] dq_meta_reg;
  logic [DATA_W-1:0] dq_sync_reg;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dq_meta_reg <= '0;
      dq_sync_reg <= '0;
    end
    else
    begin
      dq_meta_reg <= mem_dq_in;
      dq_sync_reg <= dq_meta_reg;
    end
  end

  dsram_pkg::dsram_state_e state_reg, state_next;
  dsram_pkg::dsram_cnt_t   cnt_reg, cnt_next;
  logic [ADDR_W-1:0]       addr_reg, addr_next;
  logic [DATA_W-1:0]       wdata_reg, wdata_next;
  logic                    ready_reg, ready_next;
  logic                    rvalid_reg, rvalid_next;
  logic [DATA_W-1:0]       rdata_reg, rdata_next;
  logic                    sel_b_reg, sel_b_next;
  logic                    sel_h_reg, sel_h_next;
  logic                    oe_b_reg, oe_b_next;
  logic                    we_b_reg, we_b_next;
  logic                    dq_oe_reg, dq_oe_next;
  logic                    oe_was_low_reg, oe_was_low_next;

  always_comb
  begin
    state_next      = state_reg;
    cnt_next        = cnt_reg;
    addr_next       = addr_reg;
    wdata_next      = wdata_reg;
    ready_next      = ready_reg;
    rvalid_next     = 1'b0;
    rdata_next      = rdata_reg;
    sel_b_next      = sel_b_reg;
    sel_h_next      = sel_h_reg;
    oe_b_next       = oe_b_reg;
    we_b_next       = we_b_reg;
    dq_oe_next      = dq_oe_reg;
    oe_was_low_next = oe_was_low_reg;
    unique case (state_reg)
      dsram_pkg::DSRAM_IDLE:
      begin
        if (req_valid && ready_reg)
        begin
          // address moves only here, strobe is high in idle
          addr_next  = req_addr;
          wdata_next = req_wdata;
          ready_next = 1'b0;
          sel_b_next = 1'b0;
          sel_h_next = 1'b1;
          if (req_write)
          begin
            // strobe falls together with select, device output floats
            we_b_next       = 1'b0;
            oe_b_next       = 1'b1;
            oe_was_low_next = ~oe_b_reg;
            dq_oe_next      = 1'b0;
            cnt_next        = 8'd0;
            state_next      = dsram_pkg::DSRAM_WSTRB;
          end
          else
          begin
            oe_b_next  = 1'b0;
            cnt_next   = 8'd0;
            state_next = dsram_pkg::DSRAM_READ;
          end
        end
      end
      dsram_pkg::DSRAM_WSTRB:
      begin
        cnt_next = cnt_reg + 8'd1;
        // if output enable was just low, wait out the float before driving
        if (!oe_was_low_reg || cnt_reg + 8'd1 >= FLT_CYC)
        begin
          dq_oe_next = 1'b1;
          cnt_next   = 8'd0;
          state_next = dsram_pkg::DSRAM_WDATA;
        end
      end
      dsram_pkg::DSRAM_WDATA:
      begin
        cnt_next = cnt_reg + 8'd1;
        // strobe width: data setup after drive, and never below minimum
        if (cnt_reg + 8'd1 >= DW_CYC && cnt_reg + 8'd1 >= WP_CYC)
        begin
          we_b_next  = 1'b1;
          sel_b_next = 1'b1;
          sel_h_next = 1'b0;
          cnt_next   = 8'd0;
          state_next = dsram_pkg::DSRAM_REC;
        end
      end
      dsram_pkg::DSRAM_READ:
      begin
        cnt_next = cnt_reg + 8'd1;
        // extra cycles cover the two-flop input path
        if (cnt_reg + 8'd1 >= RD_CYC)
        begin
          rdata_next  = dq_sync_reg;
          rvalid_next = 1'b1;
          oe_b_next   = 1'b1;
          sel_b_next  = 1'b1;
          sel_h_next  = 1'b0;
          cnt_next    = 8'd0;
          state_next  = dsram_pkg::DSRAM_REC;
        end
      end
      dsram_pkg::DSRAM_REC:
      begin
        cnt_next = cnt_reg + 8'd1;
        // data held past write end, bus released before next cycle
        if (cnt_reg + 8'd1 >= REC_CYC && cnt_reg + 8'd1 >= OHZ_CYC)
        begin
          dq_oe_next = 1'b0;
          ready_next = 1'b1;
          cnt_next   = 8'd0;
          state_next = dsram_pkg::DSRAM_IDLE;
        end
      end
      default:
      begin
        state_next = dsram_pkg::DSRAM_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg      <= dsram_pkg::DSRAM_IDLE;
      cnt_reg        <= 8'd0;
      addr_reg       <= '0;
      wdata_reg      <= '0;
      ready_reg      <= 1'b1;
      rvalid_reg     <= 1'b0;
      rdata_reg      <= '0;
      sel_b_reg      <= 1'b1;
      sel_h_reg      <= 1'b0;
      oe_b_reg       <= 1'b1;
      we_b_reg       <= 1'b1;
      dq_oe_reg      <= 1'b0;
      oe_was_low_reg <= 1'b0;
    end
    else
    begin
      state_reg      <= state_next;
      cnt_reg        <= cnt_next;
      addr_reg       <= addr_next;
      wdata_reg      <= wdata_next;
      ready_reg      <= ready_next;
      rvalid_reg     <= rvalid_next;
      rdata_reg      <= rdata_next;
      sel_b_reg      <= sel_b_next;
      sel_h_reg      <= sel_h_next;
      oe_b_reg       <= oe_b_next;
      we_b_reg       <= we_b_next;
      dq_oe_reg      <= dq_oe_next;
      oe_was_low_reg <= oe_was_low_next;
    end
  end

  assign req_ready           = ready_reg;
  assign rsp_valid           = rvalid_reg;
  assign rsp_rdata           = rdata_reg;
  assign mem_addr            = addr_reg;
  assign select_active_low_b = sel_b_reg;
  assign select_active_high  = sel_h_reg;
  assign output_enable_b     = oe_b_reg;
  assign write_strobe_b      = we_b_reg;
  assign mem_dq_out          = wdata_reg;
  assign mem_dq_oe           = dq_oe_reg;

  property p_addr_stable;
    @(posedge clock) disable iff (!rst_b)
      !write_strobe_b |=> $stable(mem_addr);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved in write");

  property p_strobe_width;
    @(posedge clock) disable iff (!rst_b)
      $fell(write_strobe_b) |-> !write_strobe_b [*4];
  endproperty
  a_strobe_width: assert property (p_strobe_width) else $error("write strobe too short");

  property p_strobe_with_select;
    @(posedge clock) disable iff (!rst_b)
      !write_strobe_b |-> !select_active_low_b && select_active_high && output_enable_b;
  endproperty
  a_strobe_with_select: assert property (p_strobe_with_select) else $error("strobe unselected");

  property p_no_drive_at_start;
    @(posedge clock) disable iff (!rst_b)
      $fell(write_strobe_b) |-> !mem_dq_oe;
  endproperty
  a_no_drive_at_start: assert property (p_no_drive_at_start) else $error("drove bus at write start");

  property p_drive_before_end;
    @(posedge clock) disable iff (!rst_b)
      $rose(write_strobe_b) |-> $past(mem_dq_oe, 3);
  endproperty
  a_drive_before_end: assert property (p_drive_before_end) else $error("data setup short");

  property p_read_levels;
    @(posedge clock) disable iff (!rst_b)
      !output_enable_b |-> write_strobe_b && !mem_dq_oe && !select_active_low_b;
  endproperty
  a_read_levels: assert property (p_read_levels) else $error("bad read levels");

  sequence s_write_end;
    $rose(write_strobe_b);
  endsequence
  property p_recovery;
    @(posedge clock) disable iff (!rst_b)
      s_write_end |-> !req_ready [*2] ##[1:4] req_ready;
  endproperty
  a_recovery: assert property (p_recovery) else $error("recovery wrong");

  property p_read_answer;
    @(posedge clock) disable iff (!rst_b)
      $fell(output_enable_b) |-> ##9 rsp_valid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer late");

  property p_deselect_idle;
    @(posedge clock) disable iff (!rst_b)
      req_ready |-> select_active_low_b && !select_active_high && output_enable_b;
  endproperty
  a_deselect_idle: assert property (p_deselect_idle) else $error("selected while idle");

endmodule

// ===== dsram_sram_model.sv
`timescale 1ns/1ps
module dsram_sram_model #(
  parameter int ACC_NS = 25
) (
  input  wire logic [12:0] addr,
  input  wire logic        select_active_low_b,
  input  wire logic        select_active_high,
  input  wire logic        output_enable_b,
  input  wire logic        write_strobe_b,
  input  wire logic [8:0]  dq,
  input  wire logic        host_dq_oe,
  output logic [8:0]       dq_out,
  output logic             dq_oe,
  output int               faults
);
  logic [8:0] mem [0:8191];
  logic       wr_act;
  realtime    t_fall;
  realtime    t_addr;
  // write window is the overlap of both selects and the strobe
  assign wr_act = !select_active_low_b && select_active_high && !write_strobe_b;
  // a low strobe keeps pins floating whatever output enable does
  assign dq_oe = !select_active_low_b && select_active_high && !output_enable_b
                 && write_strobe_b;
  // slow answer: old word shows until the access time has run out
  assign #(ACC_NS) dq_out = mem[addr];
  initial
  begin
    faults = 0;
    t_fall = 0;
    t_addr = 0;
    for (int i = 0; i <= 32'h1fff; i++)
      mem[i] = 9'(i) ^ 9'h1a5;
  end
  // first deasserting edge of the three ends the write
  always @(negedge wr_act)
    mem[addr] = dq;
  always @(negedge write_strobe_b)
    t_fall = $realtime;
  always @(addr)
    t_addr = $realtime;
  // judged at write end so same-time updates cannot race the check;
  // coincident strobe fall and address change is tolerated
  always @(posedge write_strobe_b)
    if (t_fall > 0 && t_addr > t_fall)
      faults++;
  // delayed look so same-edge updates settle before judging contention
  always @(host_dq_oe or dq_oe)
    #1 if (host_dq_oe && dq_oe)
      faults++;
endmodule

// ===== dsram_ctrl_tb.sv
`timescale 1ns/1ps
`include "dsram_defines.svh"
module dsram_ctrl_tb;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic        req_valid = 1'b0;
  logic        req_write = 1'b0;
  logic [12:0] req_addr = 13'h0000;
  logic [8:0]  req_wdata = 9'h000;
  logic        req_ready;
  logic        rsp_valid;
  logic [8:0]  rsp_rdata;
  logic [12:0] mem_addr;
  logic        select_active_low_b;
  logic        select_active_high;
  logic        output_enable_b;
  logic        write_strobe_b;
  logic [8:0]  mem_dq_out;
  logic        mem_dq_oe;
  logic [8:0]  dq_wire;
  logic [8:0]  dq_last = 9'h000;
  logic [8:0]  dev_dq_out;
  logic        dev_dq_oe;
  int          dev_faults;
  int          miscompares = 0;
  int          num_checks = 0;
  int          cycles = 0;
  int          low_cnt = 0;
  int          dq_cnt = 0;
  int          strobe_len = 0;
  int          setup_len = 0;
  logic [8:0]  rd;
  int          rc;
  logic [12:0] tbl_a [4] = '{13'h0000, 13'h1fff, 13'h0aaa, 13'h1555};
  logic [8:0]  tbl_d [4] = '{9'h1ff, 9'h000, 9'h155, 9'h0aa};

  // a released bus shows the inverse of its last driven value
  assign dq_wire = mem_dq_oe ? mem_dq_out : (dev_dq_oe ? dev_dq_out : ~dq_last);
  always @(posedge clock)
    if (mem_dq_oe || dev_dq_oe)
      dq_last <= dq_wire;

  dsram_ctrl dut (.clock(clock), .rst_b(rst_b), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .mem_addr(mem_addr), .select_active_low_b(select_active_low_b),
    .select_active_high(select_active_high), .output_enable_b(output_enable_b),
    .write_strobe_b(write_strobe_b), .mem_dq_out(mem_dq_out),
    .mem_dq_oe(mem_dq_oe), .mem_dq_in(dq_wire));
  dsram_sram_model dev (.addr(mem_addr), .select_active_low_b(select_active_low_b),
    .select_active_high(select_active_high), .output_enable_b(output_enable_b),
    .write_strobe_b(write_strobe_b), .dq(dq_wire), .host_dq_oe(mem_dq_oe),
    .dq_out(dev_dq_out), .dq_oe(dev_dq_oe), .faults(dev_faults));

  initial
  begin
    forever #2 clock = ~clock;
  end

  task automatic tally_and_finish();
    if (miscompares == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end

  // strobe width and data-driven span inside it, measured per write
  always @(negedge clock)
    if (write_strobe_b === 1'b0)
    begin
      low_cnt <= low_cnt + 1;
      dq_cnt <= dq_cnt + int'(mem_dq_oe === 1'b1);
    end
    else if (low_cnt != 0)
    begin
      strobe_len <= low_cnt;
      setup_len <= dq_cnt;
      low_cnt <= 0;
      dq_cnt <= 0;
    end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // junk keeps a different request up while busy; it must be ignored
  task automatic do_req(input logic wr, input logic [12:0] a, input logic [8:0] d,
                        input logic junk, output logic [8:0] rdv, output int rcy);
    int k;
    k = 1;
    rdv = 9'h000;
    rcy = 0;
    @(negedge clock);
    req_valid = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    @(negedge clock);
    req_valid = junk;
    req_addr = a ^ 13'h0001;
    req_wdata = ~d;
    while (req_ready !== 1'b1 && k < 40)
    begin
      @(negedge clock);
      k++;
      if (rsp_valid === 1'b1)
      begin
        rdv = rsp_rdata;
        rcy = k;
      end
    end
    req_valid = 1'b0;
  endtask

  task automatic t_write_read();
    for (int i = 0; i < 4; i++)
      do_req(1'b1, tbl_a[i], tbl_d[i], 1'b0, rd, rc);
    for (int i = 0; i < 4; i++)
    begin
      do_req(1'b0, tbl_a[i], 9'h000, 1'b0, rd, rc);
      check("read_data", 16'(rd), 16'(tbl_d[i]));
      check("read_lat", 16'(rc), 16'(`DSRAM_RD_CYC + 1));
    end
  endtask

  task automatic t_overwrite_refuse();
    do_req(1'b1, 13'h0010, 9'h077, 1'b0, rd, rc);
    do_req(1'b1, 13'h0011, 9'h066, 1'b0, rd, rc);
    do_req(1'b1, 13'h0010, 9'h123, 1'b1, rd, rc);
    do_req(1'b0, 13'h0010, 9'h000, 1'b0, rd, rc);
    check("overwrite", 16'(rd), 16'h0123);
    do_req(1'b0, 13'h0011, 9'h000, 1'b0, rd, rc);
    check("refused", 16'(rd), 16'h0066);
  endtask

  task automatic t_strobe_shape();
    do_req(1'b1, 13'h0bcd, 9'h1c3, 1'b0, rd, rc);
    check("strobe_wide", 16'(strobe_len >= 4), 16'h0001);
    check("data_setup", 16'(setup_len >= 3), 16'h0001);
    check("idle_pins", {11'h000, select_active_low_b, select_active_high,
          output_enable_b, write_strobe_b, mem_dq_oe}, 16'h0016);
  endtask

  initial
  begin
    repeat (20) @(negedge clock);
    check("reset_pins", {10'h000, select_active_low_b, select_active_high,
          output_enable_b, write_strobe_b, mem_dq_oe, req_ready}, 16'h002d);
    rst_b = 1'b1;
    t_write_read();
    t_overwrite_refuse();
    t_strobe_shape();
    check("bus_faults", 16'(dev_faults), 16'h0000);
    tally_and_finish();
  end
endmodule
